// *** hdl/fdc_pwr_pkg.sv ***
// Constants for the disk controller auto powerdown block
package fdc_pwr_pkg;
    // ****************************************
    // Register indices (byte address divided by four)
    // ****************************************
    localparam logic [7:0] IDX_STATUS_A = 8'h00;
    localparam logic [7:0] IDX_STATUS_B = 8'h01;
    localparam logic [7:0] IDX_DIGITAL_OUTPUT = 8'h02;
    localparam logic [7:0] IDX_RATE_MAIN = 8'h04;
    localparam logic [7:0] IDX_DATA_PORT = 8'h05;
    localparam logic [7:0] IDX_DIN_RATE_CFG = 8'h07;
    localparam logic [7:0] IDX_AUTO_POWER_CFG = 8'h08;
    localparam logic [7:0] IDX_POWER_STATUS = 8'h09;
    localparam logic [7:0] IDX_CORE_STATUS = 8'h0a;
    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int AUTO_EN_BIT = 0;
    localparam int DOR_RESET_N_BIT = 2;
    localparam int DOR_MOTOR_LSB = 4;
    localparam int DOR_MOTOR_W = 4;
    localparam int DSR_RESET_BIT = 7;
    localparam int DSR_PWRDN_BIT = 6;
    localparam logic [7:0] MSR_IDLE = 8'h80;
    localparam logic [7:0] DOR_RESET_VAL = 8'h00;
    localparam logic [7:0] DSR_RESET_VAL = 8'h02;
    localparam logic [7:0] CCR_RESET_VAL = 8'h02;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10000000;
    localparam int IDLE_TIME_MS = 10;
    localparam int IDLE_CYCLES = (CLK_HZ / 1000) * IDLE_TIME_MS;
    // ****************************************
    // AXI responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Power states
    typedef enum logic [2:0] {
        PWR_AWAKE = 3'b001,
        PWR_AUTO_DOWN = 3'b010,
        PWR_REQ_DOWN = 3'b100
    } pwr_state_e;
endpackage

// *** hdl/fdc_auto_powerdown_control.sv ***
// Auto powerdown and wake control of the disk controller with AXI4-Lite registers
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Auto powerdown allowed only while auto enable bit 0 is set.
// [RULE2] All motor enable bits of digital output must be zero.
// [RULE3] Main status must equal 80h and core interrupt must be low.
// [RULE4] Head unload timer must have expired.
// [RULE5] Dedicated 10 ms idle timer must have run out.
// [RULE6] Idle timer starts as soon as auto enable is set.
// [RULE7] Power down only when all four conditions hold together.
// [RULE8] Clearing enable cancels timer and keeps block awake.
// [RULE9] Host waits 8 us after auto wake before commands.
// [RULE10] After requested powerdown host waits 8 us or 4 us by rate.
// [RULE11] Rate register powerdown overrides auto; auto resumes after its wake.
// [RULE12] Reset pin or soft reset bits wake with full reset sequence.
// [RULE13] Register access wake keeps all state.
// [RULE14] Setting a motor bit wakes; reading digital output does not.
// [RULE15] Main status read or data port access wakes.
// [RULE16] After wake the idle timer restarts.
// [RULE17] Non-waking registers served while down, writes retained.
// [RULE18] Digital output or rate writes wake only with motor or reset.
// [RULE19] Host bus stays functional during powerdown.
// [RULE20] Motor0, select0, write data, write gate tristated while down.
// [RULE21] One powerdown output gates core clocks and drive enables.
module fdc_auto_powerdown_control #(
    parameter int IDLE_COUNT = fdc_pwr_pkg::IDLE_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Synchronous reset, high
    input wire logic hw_reset_i, // Hardware reset pin, high
    input wire logic [7:0] awaddr_i, // Write address
    input wire logic awvalid_i, // Write address valid
    output logic awready_o, // Write address ready
    input wire logic [31:0] wdata_i, // Write data
    input wire logic [3:0] wstrb_i, // Write strobes
    input wire logic wvalid_i, // Write data valid
    output logic wready_o, // Write data ready
    output logic [1:0] bresp_o, // Write response
    output logic bvalid_o, // Write response valid
    input wire logic bready_i, // Write response ready
    input wire logic [7:0] araddr_i, // Read address
    input wire logic arvalid_i, // Read address valid
    output logic arready_o, // Read address ready
    output logic [31:0] rdata_o, // Read data
    output logic [1:0] rresp_o, // Read response
    output logic rvalid_o, // Read data valid
    input wire logic rready_i, // Read data ready
    input wire logic [7:0] core_main_status_i, // Core main status
    input wire logic core_int_i, // Core interrupt, high
    input wire logic head_unloaded_i, // Head unload timer expired
    input wire logic [7:0] core_status_a_i, // Core status A
    input wire logic [7:0] core_status_b_i, // Core status B
    input wire logic [7:0] core_digital_in_i, // Core digital input
    input wire logic [7:0] core_data_rd_i, // Core data byte for reads
    output logic core_data_wr_o, // Data port write pulse
    output logic core_data_rd_o, // Data port read pulse
    output logic [7:0] core_data_wdata_o, // Data port write byte
    output logic core_soft_reset_o, // Full reset sequence pulse
    output logic [7:0] digital_output_o, // Digital output value
    output logic [7:0] data_rate_o, // Data rate select value
    output logic [7:0] rate_config_o, // Rate config value
    output logic powered_down_o, // Core in powerdown, high
    input wire logic motor0_on_n_i, // Core motor 0
    input wire logic drive0_select_n_i, // Core drive select 0
    input wire logic write_bitstream_n_i, // Core write data
    input wire logic write_gate_n_i, // Core write gate
    output logic motor0_on_n_o, // Motor 0 pin out
    output logic motor0_on_n_oe_o, // Motor 0 pin enable
    output logic drive0_select_n_o, // Drive select 0 pin out
    output logic drive0_select_n_oe_o, // Drive select 0 enable
    output logic write_bitstream_n_o, // Write data pin out
    output logic write_bitstream_n_oe_o, // Write data enable
    output logic write_gate_n_o, // Write gate pin out
    output logic write_gate_n_oe_o // Write gate enable
);
    import fdc_pwr_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    localparam int CW = $clog2(IDLE_COUNT + 1);
    logic [2:0] hwr_sync_reg;
    logic hwr_level_reg;
    logic [7:0] aw_addr_reg, ar_addr_reg;
    logic aw_full_reg, w_full_reg, ar_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] digital_output_reg, data_rate_reg, rate_config_reg, auto_power_config_reg;
    logic data_wr_reg, data_rd_reg, soft_reset_reg;
    logic [7:0] data_wdata_reg;
    logic [CW-1:0] idle_cnt_reg, idle_cnt_next;
    pwr_state_e state_reg, state_next;

    // Register index of a byte address, valid only when word aligned
    function automatic logic [7:0] word_index(input logic [7:0] a);
        word_index = {2'b00, a[7:2]};
    endfunction

    // ****************************************
    // Pin input synchroniser for hardware reset
    // ****************************************
    always_ff @(posedge clk_i) begin
        hwr_sync_reg <= {hwr_sync_reg[1:0], hw_reset_i};
        if (reset_i) begin
            hwr_level_reg <= 1'b0;
        end else if (hwr_sync_reg[1] == hwr_sync_reg[2]) begin
            hwr_level_reg <= hwr_sync_reg[2];
        end
    end

    // ****************************************
    // Write channel decode
    // ****************************************
    wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire [7:0] w_idx = word_index(aw_addr_reg);
    wire w_aligned = (aw_addr_reg[1:0] == 2'b00);
    wire w_lane0 = w_strb_reg[0];
    wire [7:0] w_byte = w_data_reg[7:0];
    wire wr_dor = do_write && w_aligned && w_lane0 && (w_idx == IDX_DIGITAL_OUTPUT);
    wire wr_dsr = do_write && w_aligned && w_lane0 && (w_idx == IDX_RATE_MAIN);
    wire wr_data = do_write && w_aligned && w_lane0 && (w_idx == IDX_DATA_PORT);
    wire wr_ccr = do_write && w_aligned && w_lane0 && (w_idx == IDX_DIN_RATE_CFG);
    wire wr_cfg = do_write && w_aligned && w_lane0 && (w_idx == IDX_AUTO_POWER_CFG);
    wire w_known = w_aligned && ((w_idx == IDX_DIGITAL_OUTPUT) || (w_idx == IDX_RATE_MAIN)
        || (w_idx == IDX_DATA_PORT) || (w_idx == IDX_DIN_RATE_CFG)
        || (w_idx == IDX_AUTO_POWER_CFG));

    // ****************************************
    // Read channel decode
    // ****************************************
    wire do_read = ar_full_reg && !rvalid_reg;
    wire [7:0] r_idx = word_index(ar_addr_reg);
    wire r_aligned = (ar_addr_reg[1:0] == 2'b00);
    wire rd_msr = do_read && r_aligned && (r_idx == IDX_RATE_MAIN);
    wire rd_data = do_read && r_aligned && (r_idx == IDX_DATA_PORT);
    logic [7:0] r_byte;
    logic r_known;
    always_comb begin
        r_byte = 8'h00;
        r_known = r_aligned;
        case (r_idx)
            IDX_STATUS_A: r_byte = core_status_a_i;
            IDX_STATUS_B: r_byte = core_status_b_i;
            IDX_DIGITAL_OUTPUT: r_byte = digital_output_reg;
            IDX_RATE_MAIN: r_byte = core_main_status_i;
            IDX_DATA_PORT: r_byte = core_data_rd_i;
            IDX_DIN_RATE_CFG: r_byte = core_digital_in_i;
            IDX_AUTO_POWER_CFG: r_byte = auto_power_config_reg;
            IDX_POWER_STATUS: r_byte = {5'h00, state_reg};
            IDX_CORE_STATUS: r_byte = {4'h0, head_unloaded_i, core_int_i,
                (idle_cnt_reg == CW'(0)), 1'b0};
            default: r_known = 1'b0;
        endcase
    end

    // ****************************************
    // AXI handshakes, one write and one read at a time
    // ****************************************
    assign awready_o = !aw_full_reg; // [RULE19]
    assign wready_o = !w_full_reg;
    assign arready_o = !ar_full_reg;
    assign bvalid_o = bvalid_reg;
    assign bresp_o = bresp_reg;
    assign rvalid_o = rvalid_reg;
    assign rresp_o = rresp_reg;
    assign rdata_o = rdata_reg;

    // Address and data holding registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            ar_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            ar_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr_i;
            end else if (do_write) begin
                aw_full_reg <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata_i;
                w_strb_reg <= wstrb_i;
            end else if (do_write) begin
                w_full_reg <= 1'b0;
            end
            if (arvalid_i && arready_o) begin
                ar_full_reg <= 1'b1;
                ar_addr_reg <= araddr_i;
            end else if (do_read) begin
                ar_full_reg <= 1'b0;
            end
        end
    end

    // Responses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (do_write) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= w_known ? RESP_OKAY : RESP_SLVERR;
            end else if (bready_i) begin
                bvalid_reg <= 1'b0;
            end
            if (do_read) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= r_known ? RESP_OKAY : RESP_SLVERR;
                rdata_reg <= {24'h000000, r_byte};
            end else if (rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Wake and reset causes
    // ****************************************
    wire dor_motor_set = wr_dor && (w_byte[DOR_MOTOR_LSB +: DOR_MOTOR_W] != 4'h0); // [RULE14]
    wire dor_soft_reset = wr_dor && !w_byte[DOR_RESET_N_BIT];
    wire dsr_soft_reset = wr_dsr && w_byte[DSR_RESET_BIT];
    wire full_reset = hwr_level_reg || dor_soft_reset || dsr_soft_reset; // [RULE12]
    // These accesses wake, as do the reset writes above; other register writes do not wake
    wire access_wake = dor_motor_set || rd_msr || rd_data || wr_data; // [RULE15] [RULE18]
    wire wake = access_wake || full_reset;
    wire dsr_down_req = wr_dsr && w_byte[DSR_PWRDN_BIT] && !w_byte[DSR_RESET_BIT];

    // ****************************************
    // Host visible registers, retained while down
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i || hwr_level_reg) begin
            digital_output_reg <= DOR_RESET_VAL;
            data_rate_reg <= DSR_RESET_VAL;
            rate_config_reg <= CCR_RESET_VAL;
        end else begin
            if (wr_dor) begin
                digital_output_reg <= w_byte; // [RULE17]
            end
            if (wr_dsr) begin
                data_rate_reg <= w_byte; // [RULE17]
            end else if (state_reg == PWR_REQ_DOWN && wake) begin
                data_rate_reg[DSR_PWRDN_BIT] <= 1'b0;
            end
            if (wr_ccr) begin
                rate_config_reg <= w_byte; // [RULE17]
            end
        end
    end

    // Configuration register is not touched by the drive reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            auto_power_config_reg <= CFG_RESET_VAL;
        end else if (wr_cfg) begin
            auto_power_config_reg <= w_byte;
        end
    end

    // Core strobes
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_wr_reg <= 1'b0;
            data_rd_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            data_wdata_reg <= 8'h00;
        end else begin
            data_wr_reg <= wr_data;
            data_rd_reg <= rd_data;
            soft_reset_reg <= full_reset;
            if (wr_data) begin
                data_wdata_reg <= w_byte;
            end
        end
    end

    // ****************************************
    // Idle timer and power state machine
    // ****************************************
    wire auto_en = auto_power_config_reg[AUTO_EN_BIT]; // [RULE1]
    wire motors_off = (digital_output_reg[DOR_MOTOR_LSB +: DOR_MOTOR_W] == 4'h0); // [RULE2]
    wire core_idle = (core_main_status_i == MSR_IDLE) && !core_int_i; // [RULE3]
    wire timer_done = (idle_cnt_reg == CW'(0)); // [RULE5]
    wire all_met = auto_en && motors_off && core_idle && head_unloaded_i // [RULE4]
        && timer_done; // [RULE7]

    // Timer reloads while disabled or on any wake, then counts down
    always_comb begin
        idle_cnt_next = idle_cnt_reg;
        if (!auto_en || wake) begin
            idle_cnt_next = CW'(IDLE_COUNT); // [RULE8] [RULE16]
        end else if (!timer_done) begin
            idle_cnt_next = idle_cnt_reg - CW'(1); // [RULE6]
        end
    end

    // Next power state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PWR_AWAKE: begin
                if (dsr_down_req) begin
                    state_next = PWR_REQ_DOWN;
                end else if (all_met && !wake) begin
                    state_next = PWR_AUTO_DOWN;
                end
            end
            PWR_AUTO_DOWN: begin
                if (dsr_down_req) begin
                    state_next = PWR_REQ_DOWN; // [RULE11]
                end else if (wake || !auto_en) begin
                    state_next = PWR_AWAKE; // [RULE13] [RULE8]
                end
            end
            PWR_REQ_DOWN: begin
                if (wake) begin
                    state_next = PWR_AWAKE; // [RULE11]
                end
            end
            default: state_next = PWR_AWAKE;
        endcase
    end

    // State and timer registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= PWR_AWAKE;
            idle_cnt_reg <= CW'(IDLE_COUNT);
        end else begin
            state_reg <= state_next;
            idle_cnt_reg <= idle_cnt_next;
        end
    end

    // ****************************************
    // Outputs to core and drive pins
    // ****************************************
    assign powered_down_o = (state_reg != PWR_AWAKE); // [RULE21]
    assign core_data_wr_o = data_wr_reg;
    assign core_data_rd_o = data_rd_reg;
    assign core_data_wdata_o = data_wdata_reg;
    assign core_soft_reset_o = soft_reset_reg;
    assign digital_output_o = digital_output_reg;
    assign data_rate_o = data_rate_reg;
    assign rate_config_o = rate_config_reg;
    assign motor0_on_n_o = motor0_on_n_i;
    assign drive0_select_n_o = drive0_select_n_i;
    assign write_bitstream_n_o = write_bitstream_n_i;
    assign write_gate_n_o = write_gate_n_i;
    // Drive pins released while down
    assign motor0_on_n_oe_o = !powered_down_o; // [RULE20]
    assign drive0_select_n_oe_o = !powered_down_o; // [RULE20]
    assign write_bitstream_n_oe_o = !powered_down_o; // [RULE20]
    assign write_gate_n_oe_o = !powered_down_o; // [RULE20]
endmodule

// *** verification/fdc_pwr_properties.sv ***
// Checker of powerdown entry, wake and pin enables
`timescale 1ns/1ps
module fdc_pwr_properties (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Reset, high
    input wire logic [7:0] core_main_status_i, // Core main status
    input wire logic core_int_i, // Core interrupt
    input wire logic head_unloaded_i, // Head unloaded
    input wire logic [7:0] digital_output_o, // Motor bits
    input wire logic [7:0] data_rate_o, // Request bit 6
    input wire logic powered_down_o, // Power state
    input wire logic core_data_wr_o, // Data write pulse
    input wire logic core_data_rd_o, // Data read pulse
    input wire logic core_soft_reset_o, // Reset pulse
    input wire logic motor0_on_n_i, // Core motor
    input wire logic motor0_on_n_o, // Motor pin
    input wire logic motor0_on_n_oe_o, // Motor enable
    input wire logic drive0_select_n_oe_o, // Select enable
    input wire logic write_gate_n_oe_o, // Gate enable
    input wire logic bvalid_o, // Write response valid
    input wire logic bready_i, // Write response ready
    input wire logic [1:0] bresp_o, // Write response
    input wire logic rvalid_o, // Read valid
    input wire logic rready_i, // Read ready
    input wire logic [31:0] rdata_o // Read data
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // ****************************************
    // Helpers
    // ****************************************
    wire logic idle_ok = core_main_status_i == 8'h80 && !core_int_i;
    sequence s_awake;
        ##[0:1] !powered_down_o;
    endsequence
    sequence s_entered;
        $rose(powered_down_o) && !data_rate_o[6];
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_tristate_down: assert property (powered_down_o |-> !motor0_on_n_oe_o &&
        !drive0_select_n_oe_o && !write_gate_n_oe_o) else $error("enable high while down");
    a_driven_awake: assert property (!powered_down_o |-> motor0_on_n_oe_o &&
        write_gate_n_oe_o) else $error("enable low while awake");
    a_pin_passes: assert property (motor0_on_n_o == motor0_on_n_i)
        else $error("motor pin not passed");
    a_entry_idle: assert property (s_entered |-> $past(idle_ok))
        else $error("down while core busy");
    a_entry_head: assert property (s_entered |-> $past(head_unloaded_i))
        else $error("down with head loaded");
    a_entry_motor: assert property (s_entered |-> $past(digital_output_o[7:4]) == 4'h0)
        else $error("down with motor on");
    a_data_wake: assert property (core_data_wr_o || core_data_rd_o |-> s_awake)
        else $error("data access left it down");
    a_reset_wake: assert property (core_soft_reset_o |-> s_awake)
        else $error("reset left it down");
    a_wake_holds: assert property ($fell(powered_down_o) |->
        (!powered_down_o || data_rate_o[6])[*8]) else $error("down too soon after wake");
    a_b_stands: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped");
    a_r_stands: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data dropped");
endmodule
bind fdc_auto_powerdown_control fdc_pwr_properties u_props (.*);

// *** verification/fdc_core_model.sv ***
// Behavioural model of the disk controller core behind the block
`timescale 1ns/1ps
module fdc_core_model (
    input wire logic clk_i, // Clock
    input wire logic busy_i, // Core executing a command
    input wire logic irq_i, // Core raises interrupt
    input wire logic loaded_i, // Head still loaded
    output logic [7:0] main_status_o, // Main status
    output logic int_o, // Interrupt
    output logic head_unloaded_o, // Head unload expired
    output logic [7:0] status_o, // Status bytes
    output logic pin_o // Drive pin value, toggles
);
    // Idle reads 80h, busy sets the command busy bit
    assign main_status_o = busy_i ? 8'h90 : 8'h80;
    assign int_o = irq_i;
    assign head_unloaded_o = !loaded_i;
    assign status_o = 8'h5a;
    initial pin_o = 1'b0;
    // Pin pattern changes every cycle
    always @(posedge clk_i) pin_o <= !pin_o;
endmodule

// *** verification/fdc_auto_powerdown_control_tb.sv ***
// Testbench of the disk controller auto powerdown block
`timescale 1ns/1ps
module fdc_auto_powerdown_control_tb;
    import fdc_pwr_pkg::*;
    localparam int IC = 20;
    logic clk_i = 0, reset_i = 1, hw_reset_i = 0, busy = 0, irq = 0, loaded = 0;
    logic [7:0] awaddr_i = 0, araddr_i = 0, main_status, st;
    logic awvalid_i = 0, wvalid_i = 0, bready_i = 1, arvalid_i = 0, rready_i = 1;
    logic [31:0] wdata_i = 0, rd;
    logic [3:0] wstrb_i = 4'hf;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_c, hu, pd, pin;
    logic [1:0] bresp_o, rresp_o, rs;
    logic [31:0] rdata_o;
    logic [7:0] digital_output, dsr, rate_config_control;
    logic m_oe, d_oe, wb_oe, wg_oe;
    int error_cnt = 0, n_compared = 0;
    fdc_core_model u_core (.clk_i(clk_i), .busy_i(busy), .irq_i(irq), .loaded_i(loaded),
        .main_status_o(main_status), .int_o(irq_c), .head_unloaded_o(hu), .status_o(st), .pin_o(pin));
    fdc_auto_powerdown_control #(.IDLE_COUNT(IC)) u_dut (.*,
        .core_main_status_i(main_status), .core_int_i(irq_c), .head_unloaded_i(hu),
        .core_status_a_i(st), .core_status_b_i(st), .core_digital_in_i(st),
        .core_data_rd_i(st), .core_data_wr_o(), .core_data_rd_o(), .core_data_wdata_o(),
        .core_soft_reset_o(), .digital_output_o(digital_output), .data_rate_o(dsr),
        .rate_config_o(rate_config_control), .powered_down_o(pd), .motor0_on_n_i(pin),
        .drive0_select_n_i(pin), .write_bitstream_n_i(pin), .write_gate_n_i(pin),
        .motor0_on_n_o(), .motor0_on_n_oe_o(m_oe), .drive0_select_n_o(),
        .drive0_select_n_oe_o(d_oe), .write_bitstream_n_o(), .write_bitstream_n_oe_o(wb_oe),
        .write_gate_n_o(), .write_gate_n_oe_o(wg_oe));
    // ****************************************
    // Clock, bus and compare tasks
    // ****************************************
    initial forever #50 clk_i = !clk_i;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Write one word; bready and rready stay high throughout
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        awaddr_i <= a; wdata_i <= d; awvalid_i <= 1; wvalid_i <= 1;
        hb = 0;
        while (!hb) begin
            @(negedge clk_i);
            ha = awvalid_i && awready_o; hw = wvalid_i && wready_o;
            hb = bvalid_o; r = bresp_o;
            @(posedge clk_i);
            if (ha) awvalid_i <= 0;
            if (hw) wvalid_i <= 0;
        end
    endtask
    // Read one word
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        araddr_i <= a; arvalid_i <= 1;
        hr = 0;
        while (!hr) begin
            @(negedge clk_i);
            ha = arvalid_i && arready_o; hr = rvalid_o; d = rdata_o; r = rresp_o;
            @(posedge clk_i);
            if (ha) arvalid_i <= 0;
        end
    endtask
    function automatic logic [7:0] ba(input logic [7:0] idx);
        return idx << 2;
    endfunction
    // Wait for auto powerdown, check state
    task automatic wait_down();
        int n;
        n = 0;
        while (!pd && n < 3 * IC + 20) begin
            @(posedge clk_i);
            n++;
        end
        #1 cmp({pd, m_oe, d_oe, wb_oe, wg_oe}, 5'b10000);
        axr(ba(IDX_POWER_STATUS), rd, rs);
        cmp(rd, 32'h2);
    endtask
    // Stays awake for three timer spans
    task automatic stay_up();
        repeat (3 * IC) @(posedge clk_i);
        #1 cmp(pd, 1'b0);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_map();
        axr(ba(IDX_DIGITAL_OUTPUT), rd, rs); cmp(rd, 32'h0);
        axr(ba(IDX_AUTO_POWER_CFG), rd, rs); cmp(rd, 32'h0);
        axr(ba(IDX_POWER_STATUS), rd, rs); cmp(rd, 32'h1);
        cmp({dsr, rate_config_control}, 16'h0202);
        axr(8'h30, rd, rs); cmp(rs, RESP_SLVERR);
        axw(8'h31, 32'h1, rs); cmp(rs, RESP_SLVERR);
        axw(ba(IDX_DIGITAL_OUTPUT), 32'h4, rs); cmp(rs, RESP_OKAY);
        stay_up();
    endtask
    task automatic t_enable();
        axw(ba(IDX_AUTO_POWER_CFG), 32'h1, rs);
        repeat (IC - 8) @(posedge clk_i);
        #1 cmp(pd, 1'b0);
        wait_down();
    endtask
    // Non-waking accesses are served while down
    task automatic t_quiet();
        axr(ba(IDX_STATUS_A), rd, rs); cmp(rd, 32'h5a);
        axr(ba(IDX_DIGITAL_OUTPUT), rd, rs); cmp(rd, 32'h4);
        axw(ba(IDX_DIN_RATE_CFG), 32'h1, rs); cmp(rate_config_control, 8'h01);
        axw(ba(IDX_DIGITAL_OUTPUT), 32'h4, rs); cmp(pd, 1'b1);
    endtask
    // Each wake source except the digital output reset bit; no core command is sent after a wake
    task automatic t_wake(input int k);
        case (k)
            0: axr(ba(IDX_RATE_MAIN), rd, rs);
            1: axr(ba(IDX_DATA_PORT), rd, rs);
            2: axw(ba(IDX_DATA_PORT), 32'h3c, rs);
            3: axw(ba(IDX_DIGITAL_OUTPUT), 32'h14, rs);
            4: axw(ba(IDX_RATE_MAIN), 32'h80, rs);
            default: begin
                hw_reset_i <= 1;
                repeat (5) @(posedge clk_i);
                hw_reset_i <= 0;
            end
        endcase
        repeat (2) @(posedge clk_i);
        #1 cmp(pd, 1'b0);
        axr(ba(IDX_DIGITAL_OUTPUT), rd, rs);
        cmp(rd, k == 5 ? 32'h0 : k == 3 ? 32'h14 : 32'h4);
        if (k == 3) axw(ba(IDX_DIGITAL_OUTPUT), 32'h4, rs);
        wait_down();
    endtask
    // Busy, interrupt, loaded head or motor on each holds the block awake
    task automatic t_block(input int k);
        axr(ba(IDX_RATE_MAIN), rd, rs);
        busy <= k == 0; irq <= k == 1; loaded <= k == 2;
        if (k == 3) axw(ba(IDX_DIGITAL_OUTPUT), 32'h84, rs);
        stay_up();
        busy <= 0; irq <= 0; loaded <= 0;
        if (k == 3) axw(ba(IDX_DIGITAL_OUTPUT), 32'h4, rs);
        wait_down();
    endtask
    // Requested powerdown overrides auto
    task automatic t_request();
        axw(ba(IDX_RATE_MAIN), 32'h40, rs);
        axr(ba(IDX_POWER_STATUS), rd, rs); cmp(rd, 32'h4);
        axr(ba(IDX_RATE_MAIN), rd, rs);
        wait_down();
        axw(ba(IDX_AUTO_POWER_CFG), 32'h0, rs);
        stay_up();
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #3000000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 0;
        @(posedge clk_i);
        t_reset_map();
        t_enable();
        t_quiet();
        for (int k = 0; k < 6; k++) t_wake(k);
        for (int k = 0; k < 4; k++) t_block(k);
        t_request();
        print_verdict();
    end
endmodule
